// ==== hdl/ccl_dither_mem.sv ====
`timescale 1ns/1ns
// Small ordered-dither threshold table, registered read data
module ccl_dither_mem #(
    parameter int AW = 4
) (
    input  wire logic          clock,
    input  wire logic [AW-1:0] addr,
    output logic      [3:0]    data_q
);
    logic [3:0] rom [0:(1<<AW)-1];
    assign rom = '{4'h0, 4'h8, 4'h2, 4'hA, 4'hC, 4'h4, 4'hE, 4'h6,
                   4'h3, 4'hB, 4'h1, 4'h9, 4'hF, 4'h7, 4'hD, 4'h5};
    // Registered read so timing matches a real memory
    always_ff @(posedge clock) begin
        data_q <= rom[addr];
    end
endmodule

// ==== hdl/ccl_map.svh ====
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH
// Register offsets on the plain port (byte addresses)
`define CCL_ADDR_W        8
`define CCL_OFF_DW4       8'h10
`define CCL_OFF_DW5       8'h14
`define CCL_OFF_HEAP      8'h20
`define CCL_OFF_STATUS    8'h24
// Field positions
`define CCL_VP_PTR_MSB    31
`define CCL_VP_PTR_LSB    5
`define CCL_DITHER_BIT    31
`define CCL_RNDDIS_BIT    30
`define CCL_ROP_MSB       19
`define CCL_ROP_LSB       16
`define CCL_LOGIC_EN_BIT  0
`define CCL_BLEND_EN_BIT  1
// Writable masks: reserved bits stay zero
`define CCL_DW4_MASK      32'hFFFFFFE0
`define CCL_DW5_MASK      32'hC00F0003
`define CCL_RESET_VAL     32'h00000000
// Dither matrix side length
`define CCL_DITHER_N      4
`endif

// ==== hdl/ccl_pkg.sv ====
package ccl_pkg;
    typedef logic [3:0] ccl_rop_t;
    typedef enum logic [1:0] {
        CCL_IDLE,
        CCL_RDDST,
        CCL_OUT
    } ccl_state_e;
endpackage

// ==== hdl/ccl_rop_unit.sv ====
`timescale 1ns/1ns
// Bitwise raster operation; code+1 is the windows_rop_code
module ccl_rop_unit #(
    parameter int W = 32
) (
    input  wire logic [3:0]   raster_op_select,
    input  wire logic [W-1:0] src,
    input  wire logic [W-1:0] dst,
    output logic      [W-1:0] res
);
    // Truth-table form: code bit k is the output
    // for (S,D) pattern k, so both nibbles repeated give the blit
    // rop byte and code plus one gives the windows_rop_code
    always_comb begin
        for (int i = 0; i < W; i++) begin
            res[i] = raster_op_select[{src[i], dst[i]}];
        end
    end
endmodule

// ==== hdl/ccl_top.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Viewport table address: pointer plus heap base
// - Dither enable dithers all components, alpha too
// - Bit30 clear cancels dither per blend data
// - Bits 19:16 select the logic function
// - Code 1 is NOR, 2 is notS and D
// - Code 0 clears to all zeros
// - No destination read when D unused
// - Nibble repeated gives blit rop byte
// - Code equals windows rop code minus one
// - Codes 3 to F per standard table
`include "ccl_map.svh"
module ccl_top #(
    parameter int CW = 8
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic [`CCL_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata_q,
    input  wire logic                   pix_valid,
    input  wire logic [4*CW-1:0]        pix_color,
    input  wire logic [1:0]             pix_x,
    input  wire logic [1:0]             pix_y,
    input  wire logic                   pix_round_hint,
    output logic                        pix_ready_q,
    output logic                        dst_rd_q,
    input  wire logic                   dst_rd_valid,
    input  wire logic [4*CW-1:0]        dst_rd_data,
    output logic                        out_valid_q,
    output logic      [4*CW-1:0]        out_color_q,
    output logic      [31:0]            viewport_addr_q
);
    import ccl_pkg::*;

    logic [31:0] dw4_q;
    logic [31:0] dw5_q;
    logic [31:0] heap_q;
    ccl_state_e  state_q;
    logic [4*CW-1:0] src_q;
    logic [4*CW-1:0] dst_q;
    logic [4*CW-1:0] rop_res;
    logic [4*CW-1:0] dith_col;
    logic [3:0]      thr_q;
    logic [3:0]      pos_q;
    logic [3:0]      thr_addr;
    logic [4*CW-1:0] pre_col;
    logic            round_q;
    logic            dither_en;
    logic            round_ok;
    logic            logic_en;
    ccl_rop_t        rop_sel;
    logic            need_dst;

    assign dither_en = dw5_q[`CCL_DITHER_BIT];
    assign logic_en  = dw5_q[`CCL_LOGIC_EN_BIT];
    assign rop_sel   = dw5_q[`CCL_ROP_MSB:`CCL_ROP_LSB];

    // True when result depends on D: cofactors on D differ
    function automatic logic uses_dst(input ccl_rop_t c);
        return (c[0] != c[1]) || (c[2] != c[3]);
    endfunction

    // Destination needed only when function uses it
    assign need_dst = logic_en && uses_dst(rop_sel);

    // Register writes; masks drop reserved bits
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dw4_q  <= `CCL_RESET_VAL;
            dw5_q  <= `CCL_RESET_VAL;
            heap_q <= `CCL_RESET_VAL;
        end else if (reg_wr) begin
            case (reg_addr)
                `CCL_OFF_DW4:  dw4_q  <= reg_wdata & `CCL_DW4_MASK;
                `CCL_OFF_DW5:  dw5_q  <= reg_wdata & `CCL_DW5_MASK;
                `CCL_OFF_HEAP: heap_q <= {reg_wdata[31:5], 5'h00};
                default: ;
            endcase
        end
    end

    // Read data one cycle after strobe; unmapped reads zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `CCL_OFF_DW4:    reg_rdata_q <= dw4_q;
                `CCL_OFF_DW5:    reg_rdata_q <= dw5_q;
                `CCL_OFF_HEAP:   reg_rdata_q <= heap_q;
                `CCL_OFF_STATUS: reg_rdata_q <= {28'h0000000,
                                     need_dst, 1'b0, state_q};
                default:         reg_rdata_q <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

    // Aligned pointer added to heap base
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            viewport_addr_q <= 32'h00000000;
        end else begin
            viewport_addr_q <= heap_q +
                {dw4_q[`CCL_VP_PTR_MSB:`CCL_VP_PTR_LSB], 5'h00};
        end
    end

    // Bitwise function per code, all codes covered
    ccl_rop_unit #(.W(4*CW)) u_rop (
        .raster_op_select (rop_sel),
        .src              (src_q),
        .dst              (dst_q),
        .res              (rop_res)
    );

    // Table follows the pins only while idle; a taken pixel keeps its
    // spot even if the pins move on to the next position
    assign thr_addr = (state_q == CCL_IDLE) ? {pix_y, pix_x} : pos_q;

    ccl_dither_mem #(.AW(4)) u_thr (
        .clock  (clock),
        .addr   (thr_addr),
        .data_q (thr_q)
    );

    assign round_ok = dw5_q[`CCL_RNDDIS_BIT] || !round_q;

    // Logic op off: the source itself goes on to the dither stage
    assign pre_col = logic_en ? rop_res : src_q;

    // Bump each component, alpha too, saturating
    always_comb begin
        dith_col = pre_col;
        if (dither_en && round_ok && thr_q[3] && thr_q[0]) begin
            for (int k = 0; k < 4; k++) begin
                if (pre_col[k*CW +: CW] != {CW{1'b1}}) begin
                    dith_col[k*CW +: CW] = pre_col[k*CW +: CW] +
                                            {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Pixel sequencer; one pixel in flight keeps ordering simple
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q     <= CCL_IDLE;
            src_q       <= '0;
            dst_q       <= '0;
            round_q     <= 1'b0;
            pos_q       <= '0;
            pix_ready_q <= 1'b1;
            dst_rd_q    <= 1'b0;
            out_valid_q <= 1'b0;
            out_color_q <= '0;
        end else begin
            dst_rd_q    <= 1'b0;
            out_valid_q <= 1'b0;
            case (state_q)
                CCL_IDLE: begin
                    if (pix_valid && pix_ready_q) begin
                        src_q       <= pix_color;
                        dst_q       <= '0;
                        round_q     <= pix_round_hint;
                        pos_q       <= {pix_y, pix_x};
                        pix_ready_q <= 1'b0;
                        // Read issued only if D used
                        if (need_dst) begin
                            dst_rd_q <= 1'b1;
                            state_q  <= CCL_RDDST;
                        end else begin
                            state_q  <= CCL_OUT;
                        end
                    end
                end
                CCL_RDDST: begin
                    if (dst_rd_valid) begin
                        dst_q   <= dst_rd_data;
                        state_q <= CCL_OUT;
                    end
                end
                CCL_OUT: begin
                    // Dither stage output is the pixel's final color
                    out_color_q <= dith_col;
                    out_valid_q <= 1'b1;
                    pix_ready_q <= 1'b1;
                    state_q     <= CCL_IDLE;
                end
                default: state_q <= CCL_IDLE;
            endcase
        end
    end

    // a_no_dst_read: guards skipping of destination reads
    a_no_dst_read: assert property (
        @(posedge clock) disable iff (!rst_n)
        dst_rd_q |-> $past(need_dst))
        else $error("destination read for function not using D");

    // a_clear_zero: guards code zero output
    a_clear_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == CCL_OUT && logic_en && rop_sel == 4'h0
         && !dither_en) |=> (out_valid_q && out_color_q == '0))
        else $error("clear function gave nonzero output");

    // a_rop_nor: guards code one
    a_rop_nor: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rop_sel == 4'h1) |-> (rop_res == ~(src_q | dst_q)))
        else $error("nor function wrong");

    // a_rop_andn: guards code two
    a_rop_andn: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rop_sel == 4'h2) |-> (rop_res == (~src_q & dst_q)))
        else $error("notsrc and dst function wrong");

    // a_rop_xor: guards code six
    a_rop_xor: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rop_sel == 4'h6) |-> (rop_res == (src_q ^ dst_q)))
        else $error("xor function wrong");

    // a_rop_orn: guards code thirteen
    a_rop_orn: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rop_sel == 4'hD) |-> (rop_res == (src_q | ~dst_q)))
        else $error("src or not dst function wrong");

    // a_vp_addr: guards viewport address sum
    a_vp_addr: assert property (
        @(posedge clock) disable iff (!rst_n)
        $stable(dw4_q) && $stable(heap_q) |=>
        viewport_addr_q == $past(heap_q) + {$past(dw4_q[31:5]), 5'h00})
        else $error("viewport address wrong");

    // a_dither_off: guards undithered path
    a_dither_off: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == CCL_OUT && !dither_en)
        |=> out_color_q == $past(pre_col))
        else $error("output changed with dither off");

    // a_round_cancel: guards cancellation when bit30 clear
    a_round_cancel: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == CCL_OUT && round_q
         && !dw5_q[`CCL_RNDDIS_BIT]) |=> out_color_q == $past(pre_col))
        else $error("dither not cancelled");

    // a_dst_read_req: guards the read when D is used
    a_dst_read_req: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == CCL_IDLE && pix_valid && pix_ready_q && need_dst)
        |=> dst_rd_q)
        else $error("destination read missing for function using D");

    // a_dither_bump: guards the alpha bump when dither fires
    a_dither_bump: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == CCL_OUT && dither_en && round_ok && thr_q[3]
         && thr_q[0] && pre_col[4*CW-1 -: CW] != {CW{1'b1}})
        |=> out_color_q[4*CW-1 -: CW] ==
            $past(pre_col[4*CW-1 -: CW]) + {{(CW-1){1'b0}}, 1'b1})
        else $error("alpha component not dithered");

    // a_logic_off: guards source pass-through with logic op off
    a_logic_off: assert property (
        @(posedge clock) disable iff (!rst_n)
        (state_q == CCL_OUT && !logic_en && !dither_en)
        |=> out_color_q == $past(src_q))
        else $error("source not passed with logic op off");

    // a_rop_set: guards code fifteen
    a_rop_set: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rop_sel == 4'hF) |-> (rop_res == {(4*CW){1'b1}}))
        else $error("set function wrong");

    // a_rop_copy: guards code twelve
    a_rop_copy: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rop_sel == 4'hC) |-> (rop_res == src_q))
        else $error("copy function wrong");

    // a_reserved_zero: guards that reserved state bits never stick
    a_reserved_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        dw4_q[4:0] == 5'h00 && dw5_q[29:20] == 10'h000
        && dw5_q[15:2] == 14'h0000)
        else $error("reserved state bits kept");
endmodule

// ==== tb/ccl_dst_mem.sv ====
`timescale 1ns/1ns
// Destination color buffer: answers each read promptly or slowly
module ccl_dst_mem #(
    parameter logic [31:0] DATA = 32'h3355_3355
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        dst_rd_q,
    output logic             dst_rd_valid,
    output logic [31:0]      dst_rd_data
);
    logic [2:0] cnt_q;
    // Countdown to the answer; a new request restarts it
    always_ff @(posedge clock) begin
        if (!rst_n)
            cnt_q <= 3'h0;
        else if (dst_rd_q)
            cnt_q <= slow ? 3'h4 : 3'h1;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    // Idle data is inverted so a stale sample can never match
    assign dst_rd_valid = (cnt_q == 3'h1);
    assign dst_rd_data  = dst_rd_valid ? DATA : ~DATA;
endmodule

// ==== tb/ccl_top_bench.sv ====
`timescale 1ns/1ns
`include "ccl_map.svh"
module ccl_top_bench;
    import ccl_pkg::*;
    localparam logic [31:0] S   = 32'h0F0F_3C3C;
    localparam logic [31:0] D   = 32'h3355_3355;
    localparam logic [31:0] C   = 32'h1020_30FF;
    localparam logic [31:0] CUP = 32'h1121_31FF;
    logic        clock     = 0;
    logic        rst_n     = 0;
    logic [7:0]  reg_addr  = '0;
    logic [31:0] reg_wdata = '0;
    logic        reg_wr    = 0;
    logic        reg_rd    = 0;
    logic        pix_valid = 0;
    logic [31:0] pix_color = '0;
    logic [1:0]  pix_x     = '0;
    logic [1:0]  pix_y     = '0;
    logic        pix_hint  = 0;
    logic        slow      = 0;
    logic [31:0] reg_rdata_q, out_color_q, viewport_addr_q, dst_rd_data;
    logic        pix_ready_q, dst_rd_q, dst_rd_valid, out_valid_q;
    logic [31:0] got;
    // Only md[2] sets bit30; a restricted variant must skip it
    logic [31:0] md [4] = '{32'h0, 32'h8000_0000,
                            32'hC000_0000, 32'h8000_0000};
    logic [31:0] dexp;
    int          failures = 0;
    int          samples_checked = 0;
    int          reads = 0;
    int          cycles = 0;
    int          bumps;

    ccl_top #(.CW(8)) u_dut (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pix_valid(pix_valid),
        .pix_color(pix_color), .pix_x(pix_x), .pix_y(pix_y),
        .pix_round_hint(pix_hint), .pix_ready_q(pix_ready_q),
        .dst_rd_q(dst_rd_q), .dst_rd_valid(dst_rd_valid),
        .dst_rd_data(dst_rd_data), .out_valid_q(out_valid_q),
        .out_color_q(out_color_q), .viewport_addr_q(viewport_addr_q));
    ccl_dst_mem #(.DATA(D)) u_mem (.clock(clock), .rst_n(rst_n),
        .slow(slow), .dst_rd_q(dst_rd_q), .dst_rd_valid(dst_rd_valid),
        .dst_rd_data(dst_rd_data));

    // Clock at 100 ns and a cycle ceiling against hangs
    initial forever #50 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (dst_rd_q === 1'b1)
            reads++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
        samples_checked++;
        if (exp !== seen) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 0;
        // Idle edge so a following write never re-raises the strobe
        // in the time step that lowered it
        @(posedge clock);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        @(posedge clock);
        chk(what, exp, reg_rdata_q);
    endtask

    // Offer one pixel, hold it until taken, wait for its result
    task automatic pix(logic [31:0] c, logic [3:0] p, logic h);
        reads = 0;
        pix_valid <= 1;
        pix_color <= c;
        pix_x <= p[1:0];
        pix_y <= p[3:2];
        pix_hint <= h;
        do @(posedge clock); while (pix_ready_q !== 1'b1);
        pix_valid <= 0;
        do @(posedge clock); while (out_valid_q !== 1'b1);
        got = out_color_q;
    endtask

    // Expected bit is the code bit indexed by {source, destination}
    function automatic logic [31:0] rop(logic [3:0] f);
        for (int i = 0; i < 32; i++)
            rop[i] = f[{S[i], D[i]}];
    endfunction

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        wr(`CCL_OFF_DW4, 32'h0012_34E0);
        wr(`CCL_OFF_HEAP, 32'h4000_001F);
        repeat (2) @(posedge clock);
        chk("viewport", 32'h4012_34E0, viewport_addr_q);
        rd(`CCL_OFF_HEAP, 32'h4000_0000, "heap");
        wr(`CCL_OFF_DW5, 32'hFFFF_FFFD);
        rd(`CCL_OFF_DW5, 32'hC00F_0001, "dw5");
        rd(8'h30, 32'h0, "unmapped");
        for (int f = 0; f < 16; f++) begin
            wr(`CCL_OFF_DW5, {12'h000, f[3:0], 16'h0001});
            slow <= f[0];
            pix(S, 4'h0, 1'b0);
            dexp = rop(f[3:0]);
            chk("rop", dexp, got);
            dexp = {31'd0, !(f inside {0, 3, 12, 15})};
            chk("reads", dexp, 32'(reads));
            rd(`CCL_OFF_STATUS, {dexp[28:0], 3'b000}, "status");
        end
        // Off, cancelled, forced on, on with no cancel request
        for (int m = 0; m < 4; m++) begin
            wr(`CCL_OFF_DW5, md[m]);
            bumps = 0;
            for (int p = 0; p < 16; p++) begin
                pix(C, p[3:0], m == 1 || m == 2);
                // Table spots 9, 11, 12 and 14 carry both bump bits
                dexp = (m >= 2 && p inside {9, 11, 12, 14}) ? CUP : C;
                if (got === CUP)
                    bumps++;
                chk("dither", dexp, got);
            end
            chk("bumped", {31'd0, m >= 2}, {31'd0, bumps != 0});
        end
        summarize();
    end
endmodule
